//--- include/epd_pkg.sv
// Shared constants, register map and types for the external port DMA engine
package epd_pkg;

  // Datapath widths
  localparam int unsigned EPD_NCH    = 2;
  localparam int unsigned EPD_ADDR_W = 32;
  localparam int unsigned EPD_CNT_W  = 16;
  localparam int unsigned EPD_TAP_W  = 27;
  localparam int unsigned EPD_PEND_W = 8;
  localparam int unsigned EPD_PADDR_W = 8;

  // Register map: channel c sits at c * stride, arbitration word on its own
  localparam logic [7:0] EPD_CH_STRIDE   = 8'h40;
  localparam logic [5:0] EPD_OFF_CTRL    = 6'h00;
  localparam logic [5:0] EPD_OFF_EXT_IDX = 6'h04;
  localparam logic [5:0] EPD_OFF_EXT_MOD = 6'h08;
  localparam logic [5:0] EPD_OFF_INT_CNT = 6'h0c;
  localparam logic [5:0] EPD_OFF_TAP_CNT = 6'h10;
  localparam logic [5:0] EPD_OFF_TAP_PTR = 6'h14;
  localparam logic [5:0] EPD_OFF_RD_IDX  = 6'h18;
  localparam logic [5:0] EPD_OFF_RD_MOD  = 6'h1c;
  localparam logic [5:0] EPD_OFF_RD_CNT  = 6'h20;
  localparam logic [5:0] EPD_OFF_CHAIN   = 6'h24;
  localparam logic [5:0] EPD_OFF_STATUS  = 6'h28;
  localparam logic [7:0] EPD_OFF_ARB     = 8'h80;

  // Status word bit positions
  localparam int unsigned EPD_ST_BUSY  = 0;
  localparam int unsigned EPD_ST_EXTB  = 1;
  localparam int unsigned EPD_ST_PHASE = 2;
  localparam int unsigned EPD_ST_DONE  = 3;

  // Transfer modes
  typedef enum logic [1:0] {
    EPD_MODE_STD = 2'h0,
    EPD_MODE_SG  = 2'h1,
    EPD_MODE_DLY = 2'h2,
    EPD_MODE_RSV = 2'h3
  } epd_mode_t;

  // Channel sequencer states, one-hot
  typedef enum logic [3:0] {
    EPD_ST_IDLE  = 4'h1,
    EPD_ST_FETCH = 4'h2,
    EPD_ST_ISSUE = 4'h4,
    EPD_ST_DRAIN = 4'h8
  } epd_state_t;

  // Channel control word, bit 6 down to bit 0
  typedef struct packed {
    logic      i2i;
    logic      pci;
    logic      icsel;
    logic      extwr;
    epd_mode_t mode;
    logic      en;
  } epd_ctrl_t;

  localparam logic [6:0] EPD_CTRL_RST = 7'h00;

  // One external access toward the memory interfaces
  typedef struct packed {
    logic                  valid;
    logic                  chan;
    logic                  write;
    logic [EPD_ADDR_W-1:0] addr;
  } epd_ext_req_t;

endpackage

//--- src/epd_dma.sv
// External port DMA engine: tap-list addressing, channel arbitration, completion events
`timescale 1ns/10ps

// Summary of operation
// [RULE1] Delay-line reads pre-modify, index register untouched
// [RULE2] Modifier register ignored during delay-line reads
// [RULE3] Access ends when block and tap counts zero
// [RULE4] Delay-line interrupt only after read phase
// [RULE5] Software sets up via descriptor, zero chain
// [RULE6] Tap starts N reads, base+tap+modifier*k
// [RULE7] Both ready: first stage picks one channel
// [RULE8] Fixed priority: channel 0 wins
// [RULE9] Channel 0 internal-only: channel 1 wins
// [RULE10] One combined group request to arbiter
// [RULE11] One interrupt per channel, nine and thirteen
// [RULE12] Scatter/gather interrupt after all tap accesses
// [RULE13] Internal-completion select: interrupt on internal side
// [RULE14] Software checks external busy before disabling
// [RULE15] Default mode: external writes done first
// [RULE16] External reads: interrupt after internal writes
// [RULE17] Chain: per-descriptor bit picks interrupt moments
// [RULE18] Same per-descriptor choice for tap-list chains
// [RULE19] Software checks memory interface before shutdown
// [RULE20] Mid-transfer disable: interrupts not dependable
// [RULE21] Delay reads counted by read count, read index
// [RULE22] Tap entries are signed offsets from memory
// [RULE23] Rotating: last winner gets lowest priority
module epd_dma
  import epd_pkg::*;
#(
  parameter int unsigned PEND_W = EPD_PEND_W
)(
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [EPD_PADDR_W-1:0]     paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  output logic                            group_req,
  input  wire logic                       group_gnt,
  output epd_pkg::epd_ext_req_t           ext_req,
  input  wire logic [1:0]                 int_ack,
  input  wire logic [1:0]                 ext_ack,
  output logic      [1:0]                 tap_req,
  output logic      [1:0][EPD_ADDR_W-1:0] tap_addr,
  input  wire logic [1:0]                 tap_valid,
  input  wire logic [EPD_TAP_W-1:0]       tap_data,
  output logic                            prog_irq_nine,
  output logic                            prog_irq_thirteen
);
  import epd_pkg::*;

  // Software-visible registers
  epd_ctrl_t             ctrl_q      [EPD_NCH];
  logic [EPD_ADDR_W-1:0] ext_index_q [EPD_NCH];
  logic [EPD_ADDR_W-1:0] ext_mod_q   [EPD_NCH];
  logic [EPD_CNT_W-1:0]  int_cnt_q   [EPD_NCH];
  logic [EPD_CNT_W-1:0]  tap_cnt_q   [EPD_NCH];
  logic [EPD_ADDR_W-1:0] tap_ptr_q   [EPD_NCH];
  logic [EPD_ADDR_W-1:0] rd_index_q  [EPD_NCH];
  logic [EPD_ADDR_W-1:0] rd_mod_q    [EPD_NCH];
  logic [EPD_CNT_W-1:0]  rd_cnt_q    [EPD_NCH];
  logic [EPD_ADDR_W-1:0] chain_q     [EPD_NCH];
  logic [1:0]            done_q;
  logic                  rot_q;

  // Sequencer working state
  epd_state_t            state_q     [EPD_NCH];
  logic [1:0]            phase_q;
  logic [EPD_CNT_W-1:0]  blk_left_q  [EPD_NCH];
  logic [EPD_CNT_W-1:0]  tap_left_q  [EPD_NCH];
  logic [EPD_ADDR_W-1:0] tp_q        [EPD_NCH];
  logic [EPD_ADDR_W-1:0] tap_off_q   [EPD_NCH];
  logic [EPD_ADDR_W-1:0] acc_q       [EPD_NCH];
  logic [PEND_W-1:0]     int_pend_q  [EPD_NCH];
  logic [PEND_W-1:0]     ext_pend_q  [EPD_NCH];
  logic [1:0]            irq_q;
  logic [1:0]            tap_req_q;
  logic [1:0][EPD_ADDR_W-1:0] tap_addr_q;

  // Bus and arbitration state
  logic                  last_q;
  logic                  group_req_q;
  epd_ext_req_t          ext_req_q;
  logic [31:0]           prdata_q;
  logic                  pready_q;
  logic                  pslverr_q;

  // Combinational helpers
  logic [1:0]            ready;
  logic                  win;
  logic                  issue;
  logic [1:0]            fire;
  logic [1:0]            tap_rd;
  logic [1:0]            dly;
  logic [EPD_ADDR_W-1:0] acc_n       [EPD_NCH];
  logic [EPD_ADDR_W-1:0] addr_c      [EPD_NCH];
  logic [1:0]            wr_c;
  logic                  wr_en;
  logic                  wch;
  logic [5:0]            woff;
  logic [31:0]           rdata_d;
  logic                  err_d;

  // Widen a one-bit event for the pending counters
  function automatic logic [PEND_W-1:0] bit_w(input logic b);
    bit_w = {{(PEND_W-1){1'b0}}, b};
  endfunction

  // Address is a word inside a channel block or the arbitration word
  function automatic logic addr_ok(input logic [EPD_PADDR_W-1:0] a);
    addr_ok = (a[1:0] == 2'h0) &&
              ((a == EPD_OFF_ARB) || (!a[7] && (a[5:0] <= EPD_OFF_STATUS)));
  endfunction

  assign wr_en = psel && penable && pready_q && pwrite && !pslverr_q;
  assign wch   = paddr[6];
  assign woff  = paddr[5:0];

  // Read mux, evaluated in the setup cycle so data is ready for the access
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    err_d   = !addr_ok(paddr);
    if (paddr == EPD_OFF_ARB)
      rdata_d = {31'h0000_0000, rot_q};
    else if (!err_d)
    begin
      case (woff)
        EPD_OFF_CTRL:    rdata_d = {25'h000_0000, ctrl_q[wch]};
        EPD_OFF_EXT_IDX: rdata_d = ext_index_q[wch];
        EPD_OFF_EXT_MOD: rdata_d = ext_mod_q[wch];
        EPD_OFF_INT_CNT: rdata_d = {16'h0000, int_cnt_q[wch]};
        EPD_OFF_TAP_CNT: rdata_d = {16'h0000, tap_cnt_q[wch]};
        EPD_OFF_TAP_PTR: rdata_d = tap_ptr_q[wch];
        EPD_OFF_RD_IDX:  rdata_d = rd_index_q[wch];
        EPD_OFF_RD_MOD:  rdata_d = rd_mod_q[wch];
        EPD_OFF_RD_CNT:  rdata_d = {16'h0000, rd_cnt_q[wch]};
        EPD_OFF_CHAIN:   rdata_d = chain_q[wch];
        EPD_OFF_STATUS:
        begin
          rdata_d[EPD_ST_BUSY]  = (state_q[wch] != EPD_ST_IDLE);
          // External busy flag: accesses still owed by the memory side
          rdata_d[EPD_ST_EXTB]  = (ext_pend_q[wch] != '0);
          rdata_d[EPD_ST_PHASE] = phase_q[wch];
          rdata_d[EPD_ST_DONE]  = done_q[wch];
        end
        default:         rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // APB handshake: zero wait states, answer registered in setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end
    else
    begin
      pready_q  <= psel && !penable;
      pslverr_q <= psel && !penable && err_d;
      prdata_q  <= (psel && !penable && !pwrite) ? rdata_d : 32'h0000_0000;
    end
  end

  // Per-channel address forming
  always_comb
  begin
    for (int c = 0; c < EPD_NCH; c++)
    begin
      dly[c]    = (ctrl_q[c].mode == EPD_MODE_DLY);
      tap_rd[c] = (ctrl_q[c].mode == EPD_MODE_SG) || (dly[c] && phase_q[c]);
      // [RULE2] read modifier replaces ext modifier
      acc_n[c]  = acc_q[c] + ((dly[c] && phase_q[c]) ? rd_mod_q[c] : ext_mod_q[c]);
      // [RULE6] base plus tap plus modifier times k
      addr_c[c] = tap_rd[c] ?
                  (((dly[c] && phase_q[c]) ? rd_index_q[c] : ext_index_q[c])
                   + tap_off_q[c] + acc_n[c]) :
                  ext_index_q[c];
      wr_c[c]   = dly[c] ? !phase_q[c] : ctrl_q[c].extwr;
    end
  end

  // First arbitration stage between the two channels
  always_comb
  begin
    for (int c = 0; c < EPD_NCH; c++)
      ready[c] = (state_q[c] == EPD_ST_ISSUE) && ctrl_q[c].en;
    win = ready[1] && !ready[0];
    // [RULE7] pick one when both ready
    if (ready == 2'b11)
    begin
      if (rot_q)
        // [RULE23] last winner goes last
        win = !last_q;
      else
        // [RULE8] [RULE9] channel 0 first unless internal-only
        win = ctrl_q[0].i2i;
    end
    issue = group_gnt && (ready != 2'b00);
    fire  = issue ? (win ? 2'b10 : 2'b01) : 2'b00;
  end

  // Group request and the external access strobe
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      group_req_q <= 1'b0;
      last_q      <= 1'b1;
      ext_req_q   <= '0;
    end
    else
    begin
      // [RULE10] one request for the pair
      group_req_q     <= (ready != 2'b00) && !issue;
      ext_req_q.valid <= issue;
      ext_req_q.chan  <= win;
      ext_req_q.write <= wr_c[win];
      ext_req_q.addr  <= addr_c[win];
      if (issue)
        last_q <= win;
    end
  end

  // Registers, sequencers and completion tracking
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rot_q     <= 1'b0;
      done_q    <= 2'b00;
      phase_q   <= 2'b00;
      irq_q     <= 2'b00;
      tap_req_q <= 2'b00;
      tap_addr_q <= '0;
      for (int c = 0; c < EPD_NCH; c++)
      begin
        ctrl_q[c]      <= EPD_CTRL_RST;
        ext_index_q[c] <= '0;
        ext_mod_q[c]   <= '0;
        int_cnt_q[c]   <= '0;
        tap_cnt_q[c]   <= '0;
        tap_ptr_q[c]   <= '0;
        rd_index_q[c]  <= '0;
        rd_mod_q[c]    <= '0;
        rd_cnt_q[c]    <= '0;
        chain_q[c]     <= '0;
        state_q[c]     <= EPD_ST_IDLE;
        blk_left_q[c]  <= '0;
        tap_left_q[c]  <= '0;
        tp_q[c]        <= '0;
        tap_off_q[c]   <= '0;
        acc_q[c]       <= '0;
        int_pend_q[c]  <= '0;
        ext_pend_q[c]  <= '0;
      end
    end
    else
    begin
      irq_q <= 2'b00;
      if (wr_en && (paddr == EPD_OFF_ARB))
        rot_q <= pwdata[0];
      for (int c = 0; c < EPD_NCH; c++)
      begin
        // Software writes; hardware updates below take precedence
        if (wr_en && !paddr[7] && (wch == c[0]))
        begin
          case (woff)
            EPD_OFF_CTRL:    ctrl_q[c]      <= pwdata[6:0];
            EPD_OFF_EXT_IDX: ext_index_q[c] <= pwdata;
            EPD_OFF_EXT_MOD: ext_mod_q[c]   <= pwdata;
            EPD_OFF_INT_CNT: int_cnt_q[c]   <= pwdata[EPD_CNT_W-1:0];
            EPD_OFF_TAP_CNT: tap_cnt_q[c]   <= pwdata[EPD_CNT_W-1:0];
            EPD_OFF_TAP_PTR: tap_ptr_q[c]   <= pwdata;
            EPD_OFF_RD_IDX:  rd_index_q[c]  <= pwdata;
            EPD_OFF_RD_MOD:  rd_mod_q[c]    <= pwdata;
            EPD_OFF_RD_CNT:  rd_cnt_q[c]    <= pwdata[EPD_CNT_W-1:0];
            EPD_OFF_CHAIN:   chain_q[c]     <= pwdata;
            EPD_OFF_STATUS:  if (pwdata[EPD_ST_DONE]) done_q[c] <= 1'b0;
            default:         ;
          endcase
        end

        // Outstanding accesses; internal-only channels owe no external ack
        int_pend_q[c] <= int_pend_q[c] + bit_w(fire[c]) - bit_w(int_ack[c]);
        ext_pend_q[c] <= ext_pend_q[c] + bit_w(fire[c] && !ctrl_q[c].i2i)
                         - bit_w(ext_ack[c] && !ctrl_q[c].i2i);

        case (state_q[c])
          EPD_ST_IDLE:
          begin
            tap_req_q[c] <= 1'b0;
            if (ctrl_q[c].en)
            begin
              phase_q[c]    <= 1'b0;
              acc_q[c]      <= '0;
              tp_q[c]       <= tap_ptr_q[c];
              tap_left_q[c] <= tap_cnt_q[c];
              blk_left_q[c] <= int_cnt_q[c];
              if ((int_cnt_q[c] == '0) ||
                  ((ctrl_q[c].mode == EPD_MODE_SG) && (tap_cnt_q[c] == '0)))
                state_q[c] <= EPD_ST_DRAIN;
              else if (ctrl_q[c].mode == EPD_MODE_SG)
                state_q[c] <= EPD_ST_FETCH;
              else
                state_q[c] <= EPD_ST_ISSUE;
            end
          end
          EPD_ST_FETCH:
          begin
            if (tap_req_q[c] && tap_valid[c])
            begin
              tap_req_q[c]  <= 1'b0;
              // [RULE22] signed tap offset from list
              tap_off_q[c]  <= {{(EPD_ADDR_W-EPD_TAP_W){tap_data[EPD_TAP_W-1]}}, tap_data};
              tp_q[c]       <= tp_q[c] + 32'h0000_0001;
              tap_left_q[c] <= tap_left_q[c] - 16'h0001;
              acc_q[c]      <= '0;
              // [RULE21] read phase counted by read count
              blk_left_q[c] <= phase_q[c] ? rd_cnt_q[c] : int_cnt_q[c];
              state_q[c]    <= EPD_ST_ISSUE;
            end
            else
            begin
              tap_req_q[c]     <= 1'b1;
              tap_addr_q[c]    <= tp_q[c];
            end
          end
          EPD_ST_ISSUE:
          begin
            if (fire[c])
            begin
              blk_left_q[c] <= blk_left_q[c] - 16'h0001;
              if (tap_rd[c])
                // [RULE1] pre-modify, index register left alone
                acc_q[c] <= acc_n[c];
              else
                ext_index_q[c] <= ext_index_q[c] + ext_mod_q[c];
              if (blk_left_q[c] == 16'h0001)
              begin
                if (tap_rd[c])
                  // [RULE3] last block of last tap ends access
                  state_q[c] <= (tap_left_q[c] == '0) ? EPD_ST_DRAIN : EPD_ST_FETCH;
                else if (dly[c])
                begin
                  // [RULE21] reads start where writes ended
                  phase_q[c]    <= 1'b1;
                  rd_index_q[c] <= ext_index_q[c] + ext_mod_q[c];
                  tp_q[c]       <= tap_ptr_q[c];
                  tap_left_q[c] <= tap_cnt_q[c];
                  state_q[c]    <= ((tap_cnt_q[c] == '0) || (rd_cnt_q[c] == '0)) ?
                                   EPD_ST_DRAIN : EPD_ST_FETCH;
                end
                else
                  state_q[c] <= EPD_ST_DRAIN;
              end
            end
          end
          EPD_ST_DRAIN:
          begin
            // [RULE13] [RULE15] [RULE16] completion point by select bit
            if ((int_pend_q[c] == '0) && (ctrl_q[c].icsel || (ext_pend_q[c] == '0)))
            begin
              // [RULE4] [RULE12] [RULE17] [RULE18] chain end or per-descriptor bit
              irq_q[c]     <= (chain_q[c] == '0) || ctrl_q[c].pci;
              done_q[c]    <= 1'b1;
              ctrl_q[c].en <= 1'b0;
              state_q[c]   <= EPD_ST_IDLE;
            end
          end
          default:
            state_q[c] <= EPD_ST_IDLE;
        endcase

        // Disable aborts the sequence without a completion event
        if (!ctrl_q[c].en && (state_q[c] != EPD_ST_IDLE))
        begin
          state_q[c]   <= EPD_ST_IDLE;
          tap_req_q[c] <= 1'b0;
        end
      end
    end
  end

  // Outputs straight from flops
  assign prdata    = prdata_q;
  assign pready    = pready_q;
  assign pslverr   = pslverr_q;
  assign group_req = group_req_q;
  assign ext_req   = ext_req_q;
  assign tap_req   = tap_req_q;
  assign tap_addr  = tap_addr_q;
  // [RULE11] channel 0 on nine, channel 1 on thirteen
  assign prog_irq_nine     = irq_q[0];
  assign prog_irq_thirteen = irq_q[1];

endmodule // epd_dma

//--- verif/epd_dma_asserts.sv
// Port-level checker for the external port DMA engine
`timescale 1ns/10ps
module epd_dma_asserts
  import epd_pkg::*;
(
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic [EPD_PADDR_W-1:0] paddr,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire logic                   group_gnt,
  input wire epd_pkg::epd_ext_req_t  ext_req,
  input wire logic [1:0]             int_ack,
  input wire logic [1:0]             ext_ack,
  input wire logic [1:0]             tap_req,
  input wire logic [1:0]             tap_valid,
  input wire logic                   prog_irq_nine,
  input wire logic                   prog_irq_thirteen
);
  // Single domain, so one clock and one reset for all
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  ready_setup_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_origin_a: assert property (pready |-> $past(psel && !penable))
    else $error("ready without setup");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  err_decode_a: assert property (psel && !penable &&
    (paddr[7] ? paddr != 8'h80 : paddr[5:0] > 6'h28) |=> pslverr)
    else $error("unmapped address accepted");
  issue_grant_a: assert property (ext_req.valid |-> $past(group_gnt))
    else $error("access issued without grant");
  tap_hold_a: assert property (tap_req[0] && !tap_valid[0] |=> tap_req[0])
    else $error("tap fetch dropped early");
  irq_pulse_a: assert property (prog_irq_nine |=> !prog_irq_nine)
    else $error("completion pulse too long");
  irq_nine_cause_a: assert property (prog_irq_nine |->
    $past(int_ack[0] | ext_ack[0], 2) || $past(int_ack[0] | ext_ack[0], 1)
    || $past(int_ack[0] | ext_ack[0], 3)) else $error("channel 0 completion without ack");
  irq_thirteen_cause_a: assert property (prog_irq_thirteen |->
    $past(int_ack[1] | ext_ack[1], 2) || $past(int_ack[1] | ext_ack[1], 1)
    || $past(int_ack[1] | ext_ack[1], 3)) else $error("channel 1 completion without ack");

  // Main scenarios reached
  cover property (prog_irq_nine);
  cover property (prog_irq_thirteen);
  cover property (pslverr);
endmodule // epd_dma_asserts

bind epd_dma epd_dma_asserts u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .group_gnt(group_gnt),
  .ext_req(ext_req), .int_ack(int_ack), .ext_ack(ext_ack), .tap_req(tap_req),
  .tap_valid(tap_valid), .prog_irq_nine(prog_irq_nine), .prog_irq_thirteen(prog_irq_thirteen)
);

//--- verif/epd_mem_model.sv
// Behavioural memory side and bus arbiter facing the DMA engine
`timescale 1ns/10ps
module epd_mem_model
  import epd_pkg::*;
#(
  parameter logic [26:0] TAPS [4] = '{default: 27'h0}
)(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  stall,
  input  wire logic [3:0]            int_dly,
  input  wire logic [3:0]            ext_dly,
  input  wire epd_pkg::epd_ext_req_t ext_req,
  input  wire logic [1:0]            tap_req,
  input  wire logic [1:0][31:0]      tap_addr,
  output logic                       group_gnt,
  output logic [1:0]                 int_ack,
  output logic [1:0]                 ext_ack,
  output logic [1:0]                 tap_valid,
  output logic [26:0]                tap_data
);
  logic [1:0][15:0] hist_q;
  logic             sel;

  // Access history per channel; acks fall out at chosen delays
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      hist_q <= '0;
    else
      for (int c = 0; c < 2; c++)
        hist_q[c] <= {hist_q[c][14:0], ext_req.valid && ext_req.chan == c[0]};

  // Slow answers come from larger delays
  always_comb
    for (int c = 0; c < 2; c++)
    begin
      int_ack[c] = hist_q[c][int_dly];
      ext_ack[c] = hist_q[c][ext_dly];
    end

  // Channel 0 served first when both fetch
  assign sel = !tap_req[0];

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      tap_valid <= 2'b00;
      tap_data  <= '0;
      group_gnt <= 1'b0;
    end
    else
    begin
      group_gnt <= !stall;
      tap_valid <= 2'b00;
      tap_data  <= ~tap_data; // Idle line toggles, so it shows the last entry only every other cycle
      if (tap_valid == 2'b00 && tap_req != 2'b00)
      begin
        tap_valid[sel] <= 1'b1;
        tap_data       <= TAPS[tap_addr[sel][1:0]];
      end
    end
endmodule // epd_mem_model

//--- verif/epd_dma_tb.sv
// Self-checking bench for the external port DMA engine
`timescale 1ns/10ps
module epd_dma_tb;
  import epd_pkg::*;
  localparam logic [26:0] TAPS [4] = '{27'h0000005, 27'h7fffffd, 27'h10, 27'h0};
  logic             pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]       paddr = 8'h00;
  logic [31:0]      pwdata = 32'h0, prdata, rd;
  logic             pready, pslverr, group_req, group_gnt, er, stall = 1'b0;
  logic [1:0]       int_ack, ext_ack, tap_req, tap_valid, irq;
  logic [1:0][31:0] tap_addr;
  logic [26:0]      tap_data;
  logic [3:0]       int_dly = 4'h1, ext_dly = 4'h1;
  epd_ext_req_t     ext_req, q [$];
  int               n_errors = 0, checked = 0, cyc = 0, got = 0, lastc = 0;
  int               nirq [2] = '{0, 0}, irqc [2] = '{0, 0}, ackc [2] = '{0, 0};

  epd_dma u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .group_req(group_req), .group_gnt(group_gnt), .ext_req(ext_req),
    .int_ack(int_ack), .ext_ack(ext_ack), .tap_req(tap_req), .tap_addr(tap_addr),
    .tap_valid(tap_valid), .tap_data(tap_data), .prog_irq_nine(irq[0]),
    .prog_irq_thirteen(irq[1]));
  epd_mem_model #(.TAPS(TAPS)) u_mem (.pclk(pclk), .presetn(presetn), .stall(stall),
    .int_dly(int_dly), .ext_dly(ext_dly), .ext_req(ext_req), .tap_req(tap_req),
    .tap_addr(tap_addr), .group_gnt(group_gnt), .int_ack(int_ack), .ext_ack(ext_ack),
    .tap_valid(tap_valid), .tap_data(tap_data));

  // 20 MHz clock
  always #25 pclk = ~pclk;

  // Log of issued accesses, acks and completion pulses; hang guard
  always @(posedge pclk)
  begin
    cyc++;
    if (ext_req.valid === 1'b1)
    begin
      q.push_back(ext_req);
      lastc = cyc;
    end
    for (int c = 0; c < 2; c++)
    begin
      if (ext_ack[c] === 1'b1)
        ackc[c] = cyc;
      if (irq[c] === 1'b1)
      begin
        nirq[c]++;
        irqc[c] = cyc;
      end
    end
    if (cyc == 20000)
    begin
      n_errors++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [34:0] e, input logic [34:0] g);
    checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic [31:0] sx(input logic [26:0] t);
    return {{5{t[26]}}, t};
  endfunction

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask

  // Setup, access held until ready is sampled, then release
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic c, input logic [5:0] o, input logic [31:0] d);
    apb(1'b1, {1'b0, c, o}, d);
  endtask

  task automatic setup(input logic c, input logic [31:0] ix, em, ic, tc, rm, rc, ch);
    wr(c, EPD_OFF_EXT_IDX, ix);
    wr(c, EPD_OFF_EXT_MOD, em);
    wr(c, EPD_OFF_INT_CNT, ic);
    wr(c, EPD_OFF_TAP_CNT, tc);
    wr(c, EPD_OFF_TAP_PTR, 32'h0);
    wr(c, EPD_OFF_RD_MOD, rm);
    wr(c, EPD_OFF_RD_CNT, rc);
    wr(c, EPD_OFF_CHAIN, ch);
  endtask

  // Start a channel, poll its done flag, let trailing acks land
  task automatic go(input logic c, input logic [31:0] ctl);
    int n;
    n = nirq[c];
    wr(c, EPD_OFF_STATUS, 32'h8);
    q.delete();
    wr(c, EPD_OFF_CTRL, ctl);
    rd = 32'h0;
    while (rd[EPD_ST_DONE] !== 1'b1)
      apb(1'b0, {1'b0, c, EPD_OFF_STATUS}, 32'h0);
    repeat (16) @(posedge pclk);
    got = nirq[c] - n;
  endtask

  // Both channels pending behind a stalled grant, three priority setups
  task automatic t_arb();
    logic [31:0] c0 [3] = '{32'h09, 32'h09, 32'h49};
    logic [3:0]  ex [3] = '{4'b0101, 4'b0011, 4'b1100};
    for (int v = 0; v < 3; v++)
    begin
      stall <= 1'b1;
      apb(1'b1, EPD_OFF_ARB, 32'(v == 0));
      setup(1'b0, 32'h100, 32'h1, 32'h2, 32'h0, 32'h0, 32'h0, 32'h0);
      setup(1'b1, 32'h400, 32'h1, 32'h2, 32'h0, 32'h0, 32'h0, 32'h0);
      q.delete();
      wr(1'b0, EPD_OFF_CTRL, c0[v]);
      wr(1'b1, EPD_OFF_CTRL, 32'h09);
      chk("group request", 35'h1, 35'(group_req));
      stall <= 1'b0;
      while (q.size() < 4)
        @(posedge pclk);
      repeat (20) @(posedge pclk);
      for (int i = 0; i < 4; i++)
        chk("winner", 35'(ex[v][3-i]), 35'(q[i].chan));
    end
  endtask

  // Standard write, access completion then internal completion
  task automatic t_std();
    ext_dly <= 4'h9;
    for (int i = 0; i < 2; i++)
    begin
      setup(1'b0, 32'h100, 32'h4, 32'h2, 32'h0, 32'h0, 32'h0, 32'h0);
      go(1'b0, i ? 32'h19 : 32'h09);
      chk("std first", {3'b101, 32'h100}, q[0]);
      chk("std second", {3'b101, 32'h104}, q[1]);
      chk("irq count", 35'h1, 35'(got));
      chk("irq vs ext ack", 35'(i == 0), 35'(irqc[0] > ackc[0]));
      chk("busy at done", 35'(i), 35'(rd[EPD_ST_EXTB]));
    end
    ext_dly <= 4'h1;
  endtask

  // Delay line: one write, then two taps of two reads each
  task automatic t_dly();
    logic [31:0] a;
    setup(1'b0, 32'h200, 32'h8, 32'h1, 32'h2, 32'h2, 32'h2, 32'h0);
    go(1'b0, 32'h05);
    chk("line write", {3'b101, 32'h200}, q[0]);
    for (int j = 0; j < 2; j++)
      for (int k = 1; k <= 2; k++)
      begin
        a = 32'h208 + sx(TAPS[j]) + 32'(2 * k);
        chk("line read", {3'b100, a}, q[2 * j + k]);
      end
    chk("access count", 35'd5, 35'(q.size()));
    chk("line irq", 35'h1, 35'(got));
    chk("irq after reads", 35'h1, 35'(irqc[0] > lastc));
    apb(1'b0, EPD_OFF_EXT_IDX, 32'h0);
    chk("ext index", 35'h208, 35'(rd));
  endtask

  // Gather on channel 1, chained without then with per-descriptor irq
  task automatic t_sg();
    logic [31:0] a;
    for (int p = 0; p < 2; p++)
    begin
      setup(1'b1, 32'h300, 32'h1, 32'h2, 32'h2, 32'h0, 32'h0, 32'h40);
      go(1'b1, p ? 32'h23 : 32'h03);
      chk("chain irq", 35'(p), 35'(got));
      for (int j = 0; j < 2; j++)
        for (int k = 1; k <= 2; k++)
        begin
          a = 32'h300 + sx(TAPS[j]) + 32'(k);
          chk("gather read", {3'b110, a}, q[2 * j + k - 1]);
        end
      chk("irq after taps", 35'(p), 35'(irqc[1] > lastc));
    end
    apb(1'b0, 8'h2c, 32'h0);
    chk("unmapped error", 35'h1, 35'(er));
    chk("unmapped data", 35'h0, 35'(rd));
  endtask

  // Main sequence
  initial
  begin
    do_reset();
    t_arb();
    t_std();
    do_reset();
    t_dly();
    t_sg();
    give_verdict();
  end
endmodule // epd_dma_tb
